/* File: hw/ifb_regs.svh */
`ifndef IFB_REGS_SVH
`define IFB_REGS_SVH

`define IFB_ADDR_W         12
`define IFB_REG_W          16

`define IFB_OFS_FLAG       12'h000
`define IFB_OFS_ENABLE     12'h004
`define IFB_OFS_MASK       12'h008
`define IFB_OFS_FLAG_CLR   12'h00C
`define IFB_OFS_PENDING    12'h010

`define IFB_FLAG_IMPL      16'hCE7E
`define IFB_EN_IMPL        16'h7FFF
`define IFB_AUDIO_BITS     16'hC000

`define IFB_FLAG_RST       16'h0000
`define IFB_EN_RST         16'h0000
`define IFB_MASK_RST       16'h0000

`define IFB_BIT_AUDIO_L    15
`define IFB_BIT_AUDIO_R    14
`define IFB_BIT_QEI2       11
`define IFB_BIT_FLTA2      10
`define IFB_BIT_PWM2_ERR   9
`define IFB_BIT_CRC        3

`define IFB_BIT_UART1_RX   11
`define IFB_BIT_TIMER2     7
`define IFB_BIT_CMP        2
`define IFB_BIT_I2C1_MST   1
`define IFB_BIT_I2C1_SLV   0

`define IFB_ANSWER_CYCLES  1

`endif

/* File: hw/ifb_pkg.sv */
`include "ifb_regs.svh"

package ifb_pkg;

    typedef struct packed {
        logic                    psel;
        logic                    penable;
        logic                    pwrite;
        logic [`IFB_ADDR_W-1:0]  paddr;
        logic [31:0]             pwdata;
    } ifb_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ifb_apb_rsp_t;

    typedef enum logic {
        IFB_ST_IDLE   = 1'b0,
        IFB_ST_ANSWER = 1'b1
    } ifb_bus_state_t;

endpackage

/* File: hw/ifb_sticky_bits.sv */
`timescale 1ns/10ps
`include "ifb_regs.svh"

module ifb_sticky_bits
    import ifb_pkg::*;
#(
    parameter int         W    = 16,
    parameter logic [W-1:0] IMPL = '1
) (
    input  wire logic         mclk_in,    // System clock
    input  wire logic         reset_in,   // Synchronous reset
    input  wire logic         clk_en_in,  // Freezes state when low
    input  wire logic [W-1:0] set_in,     // Hardware set requests
    input  wire logic         wr_in,      // Write value
    input  wire logic         clr_in,     // Write one to clear
    input  wire logic [W-1:0] data_in,    // Written data
    output logic      [W-1:0] q_out       // Flag bits
);

    generate
        if (W < 1) begin : g_chk
            $error("W must be at least 1");
        end
    endgenerate

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            if (IMPL[i]) begin : g_impl
                // A hardware set in the clearing cycle wins
                always_ff @(posedge mclk_in) begin
                    if (reset_in)
                        q_out[i] <= 1'b0;
                    else if (clk_en_in) begin
                        if (set_in[i])
                            q_out[i] <= 1'b1;
                        else if (wr_in)
                            q_out[i] <= data_in[i];
                        else if (clr_in && data_in[i])
                            q_out[i] <= 1'b0;
                    end
                end
            end else begin : g_none
                assign q_out[i] = 1'b0;
            end
        end
    endgenerate

endmodule // ifb_sticky_bits

/* File: hw/ifb_apb_slave.sv */
`timescale 1ns/10ps
`include "ifb_regs.svh"

module ifb_apb_slave
    import ifb_pkg::*;
(
    input  wire logic         mclk_in,     // System clock
    input  wire logic         reset_in,    // Synchronous reset
    input  wire logic         clk_en_in,   // Freezes state when low
    input  wire ifb_apb_req_t req_in,      // APB request
    input  wire logic [31:0]  rd_data_in,  // Read data for paddr
    input  wire logic         hit_in,      // paddr is mapped
    output ifb_apb_rsp_t      rsp_out,     // Registered APB answer
    output logic              wr_stb_out   // Write takes effect now
);

    ifb_bus_state_t state_reg;

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state_reg <= IFB_ST_IDLE;
            rsp_out   <= '0;
        end else if (clk_en_in) begin
            unique case (state_reg)
                IFB_ST_IDLE: begin
                    // Answer is prepared during the setup cycle
                    if (req_in.psel && !req_in.penable) begin
                        state_reg       <= IFB_ST_ANSWER;
                        rsp_out.pready  <= 1'b1;
                        rsp_out.pslverr <= !hit_in;
                        rsp_out.prdata  <= (hit_in && !req_in.pwrite) ?
                                           rd_data_in : 32'h0000_0000;
                    end
                end
                IFB_ST_ANSWER: begin
                    if (req_in.psel && req_in.penable) begin
                        state_reg <= IFB_ST_IDLE;
                        rsp_out   <= '0;
                    end
                end
            endcase
        end
    end

    assign wr_stb_out = clk_en_in && (state_reg == IFB_ST_ANSWER) &&
                        req_in.psel && req_in.penable &&
                        req_in.pwrite && !rsp_out.pslverr;

endmodule // ifb_apb_slave

/* File: hw/ifb_bank.sv */
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "ifb_regs.svh"

module ifb_bank
    import ifb_pkg::*;
#(
    parameter int HAS_AUDIO_DAC = 1
) (
    input  wire logic         mclk_in,          // 250 MHz system clock
    input  wire logic         reset_in,         // Synchronous, high
    input  wire logic         clk_en_in,        // Freezes state when low
    input  wire ifb_apb_req_t apb_req_in,       // APB request
    output ifb_apb_rsp_t      apb_rsp_out,      // APB answer
    input  wire logic [15:0]  flag_req_in,      // Flag source requests
    input  wire logic [15:0]  enable_req_in,    // Enabled-side requests
    output logic [15:0]       gated_req_out,    // Requests past enables
    output logic              irq_out           // Unmasked flag pending
);

    localparam logic [15:0] FLAG_IMPL = (HAS_AUDIO_DAC != 0) ?
        `IFB_FLAG_IMPL : (`IFB_FLAG_IMPL & ~`IFB_AUDIO_BITS);

    // Named source positions that the flag bank must keep
    localparam logic [15:0] SRC_FLAGS =
        (16'h0001 << `IFB_BIT_QEI2)     |
        (16'h0001 << `IFB_BIT_FLTA2)    |
        (16'h0001 << `IFB_BIT_PWM2_ERR) |
        (16'h0001 << `IFB_BIT_CRC);

    // Named source positions that the enable register must keep
    localparam logic [15:0] SRC_ENABLES =
        (16'h0001 << `IFB_BIT_UART1_RX) |
        (16'h0001 << `IFB_BIT_TIMER2)   |
        (16'h0001 << `IFB_BIT_CMP)      |
        (16'h0001 << `IFB_BIT_I2C1_MST) |
        (16'h0001 << `IFB_BIT_I2C1_SLV);

    generate
        if (HAS_AUDIO_DAC != 0 && HAS_AUDIO_DAC != 1) begin : g_chk
            $error("HAS_AUDIO_DAC must be 0 or 1");
        end
        if ((SRC_FLAGS & FLAG_IMPL) != SRC_FLAGS) begin : g_chk_flags
            $error("Flag bank lacks a source bit");
        end
        if ((SRC_ENABLES & `IFB_EN_IMPL) != SRC_ENABLES) begin : g_chk_en
            $error("Enable register lacks a source bit");
        end
    endgenerate

    logic [15:0] interrupt_flag_status_4;
    logic [15:0] interrupt_enable_control_1;
    logic [15:0] irq_mask_reg;
    logic [15:0] gated_req_reg;
    logic        irq_reg;
    logic [31:0] rd_data;
    logic        hit;
    logic        wr_stb;
    logic        wr_flag;
    logic        clr_flag;
    logic [15:0] wdata;
    logic [`IFB_ADDR_W-1:0] addr;

    assign addr  = apb_req_in.paddr;
    assign wdata = apb_req_in.pwdata[15:0];

    // Read mux; bits 31:16 always zero
    always_comb begin
        rd_data = 32'h0000_0000;
        hit     = 1'b1;
        unique case (addr)
            `IFB_OFS_FLAG:     rd_data[15:0] = interrupt_flag_status_4;
            `IFB_OFS_ENABLE:   rd_data[15:0] = interrupt_enable_control_1;
            `IFB_OFS_MASK:     rd_data[15:0] = irq_mask_reg;
            `IFB_OFS_FLAG_CLR: rd_data[15:0] = interrupt_flag_status_4;
            `IFB_OFS_PENDING:  rd_data[15:0] = interrupt_flag_status_4 &
                                               irq_mask_reg;
            default:           hit = 1'b0;
        endcase
    end

    ifb_apb_slave u_apb (
        .mclk_in    (mclk_in),
        .reset_in   (reset_in),
        .clk_en_in  (clk_en_in),
        .req_in     (apb_req_in),
        .rd_data_in (rd_data),
        .hit_in     (hit),
        .rsp_out    (apb_rsp_out),
        .wr_stb_out (wr_stb)
    );

    assign wr_flag  = wr_stb && (addr == `IFB_OFS_FLAG);
    assign clr_flag = wr_stb && (addr == `IFB_OFS_FLAG_CLR);

    // Flag bank; unimplemented and absent audio bits stay zero
    ifb_sticky_bits #(
        .W    (16),
        .IMPL (FLAG_IMPL)
    ) u_flags (
        .mclk_in   (mclk_in),
        .reset_in  (reset_in),
        .clk_en_in (clk_en_in),
        .set_in    (flag_req_in & FLAG_IMPL),
        .wr_in     (wr_flag),
        .clr_in    (clr_flag),
        .data_in   (wdata),
        .q_out     (interrupt_flag_status_4)
    );

    always_ff @(posedge mclk_in) begin
        if (reset_in)
            interrupt_enable_control_1 <= `IFB_EN_RST;
        else if (clk_en_in && wr_stb && addr == `IFB_OFS_ENABLE)
            interrupt_enable_control_1 <= wdata & `IFB_EN_IMPL;
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in)
            irq_mask_reg <= `IFB_MASK_RST;
        else if (clk_en_in && wr_stb && addr == `IFB_OFS_MASK)
            irq_mask_reg <= wdata & FLAG_IMPL;
    end

    // Each enable bit gates its own source request
    always_ff @(posedge mclk_in) begin
        if (reset_in)
            gated_req_reg <= 16'h0000;
        else if (clk_en_in)
            gated_req_reg <= enable_req_in &
                             interrupt_enable_control_1;
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in)
            irq_reg <= 1'b0;
        else if (clk_en_in)
            irq_reg <= |(interrupt_flag_status_4 & irq_mask_reg);
    end

    assign gated_req_out = gated_req_reg;
    assign irq_out       = irq_reg;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);

    property p_flag_set;
        clk_en_in && (flag_req_in & FLAG_IMPL) != 16'h0000
        |=> (interrupt_flag_status_4 & $past(flag_req_in & FLAG_IMPL))
            == $past(flag_req_in & FLAG_IMPL);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("Flag not set after its request");

    property p_flag_quiet;
        clk_en_in && !flag_req_in[`IFB_BIT_CRC] && !wr_stb &&
        !interrupt_flag_status_4[`IFB_BIT_CRC]
        |=> !interrupt_flag_status_4[`IFB_BIT_CRC];
    endproperty
    a_flag_quiet: assert property (p_flag_quiet)
        else $error("Flag set without a request");

    property p_qei2;
        clk_en_in && flag_req_in[`IFB_BIT_QEI2]
        |=> interrupt_flag_status_4[`IFB_BIT_QEI2];
    endproperty
    a_qei2: assert property (p_qei2)
        else $error("Decoder 2 event not in bit 11");

    property p_flta2;
        clk_en_in && flag_req_in[`IFB_BIT_FLTA2] && !wr_flag
        |=> interrupt_flag_status_4[`IFB_BIT_FLTA2];
    endproperty
    a_flta2: assert property (p_flta2)
        else $error("PWM2 fault A not in bit 10");

    property p_pwm2_err;
        clk_en_in && flag_req_in[`IFB_BIT_PWM2_ERR]
        ##1 !clk_en_in [*2]
        |-> interrupt_flag_status_4[`IFB_BIT_PWM2_ERR];
    endproperty
    a_pwm2_err: assert property (p_pwm2_err)
        else $error("PWM2 error not held in bit 9");

    property p_crc;
        clk_en_in && flag_req_in[`IFB_BIT_CRC] && !wr_stb
        |=> interrupt_flag_status_4[`IFB_BIT_CRC];
    endproperty
    a_crc: assert property (p_crc)
        else $error("CRC request not in bit 3");

    property p_audio;
        (HAS_AUDIO_DAC == 0)
        |-> interrupt_flag_status_4[`IFB_BIT_AUDIO_L:`IFB_BIT_AUDIO_R]
            == 2'b00;
    endproperty
    a_audio: assert property (p_audio)
        else $error("Audio flag set without a DAC");

    property p_audio_set;
        (HAS_AUDIO_DAC == 1) && clk_en_in &&
        flag_req_in[`IFB_BIT_AUDIO_L] && flag_req_in[`IFB_BIT_AUDIO_R]
        |=> interrupt_flag_status_4[15:14] == 2'b11;
    endproperty
    a_audio_set: assert property (p_audio_set)
        else $error("Audio flags not in bits 15 and 14");

    property p_gate;
        clk_en_in |=> gated_req_out ==
            $past(enable_req_in & interrupt_enable_control_1);
    endproperty
    a_gate: assert property (p_gate)
        else $error("Enabled request gating wrong");

    property p_gate_block;
        !interrupt_enable_control_1[`IFB_BIT_UART1_RX] && clk_en_in
        |=> !gated_req_out[`IFB_BIT_UART1_RX];
    endproperty
    a_gate_block: assert property (p_gate_block)
        else $error("Disabled request passed");

    property p_en_uart;
        wr_stb && addr == `IFB_OFS_ENABLE
        |=> interrupt_enable_control_1[`IFB_BIT_UART1_RX]
            == $past(wdata[`IFB_BIT_UART1_RX]);
    endproperty
    a_en_uart: assert property (p_en_uart)
        else $error("UART1 receive enable not in bit 11");

    property p_en_timer2;
        wr_stb && addr == `IFB_OFS_ENABLE && wdata[`IFB_BIT_TIMER2]
        ##1 (!wr_stb) [*3]
        |-> interrupt_enable_control_1[`IFB_BIT_TIMER2];
    endproperty
    a_en_timer2: assert property (p_en_timer2)
        else $error("Timer two enable not held in bit 7");

    property p_en_cmp;
        wr_stb && addr == `IFB_OFS_ENABLE
        |=> interrupt_enable_control_1[`IFB_BIT_CMP]
            == $past(wdata[`IFB_BIT_CMP]);
    endproperty
    a_en_cmp: assert property (p_en_cmp)
        else $error("Comparator enable not in bit 2");

    property p_en_i2c_mst;
        wr_stb && addr == `IFB_OFS_ENABLE && wdata[`IFB_BIT_I2C1_MST]
        |=> interrupt_enable_control_1[`IFB_BIT_I2C1_MST]
            && enable_req_in[`IFB_BIT_I2C1_MST] && clk_en_in |=>
            gated_req_out[`IFB_BIT_I2C1_MST];
    endproperty
    a_en_i2c_mst: assert property (p_en_i2c_mst)
        else $error("I2C1 master enable not in bit 1");

    property p_en_i2c_slv;
        wr_stb && addr == `IFB_OFS_ENABLE && !wdata[`IFB_BIT_I2C1_SLV]
        |=> !interrupt_enable_control_1[`IFB_BIT_I2C1_SLV];
    endproperty
    a_en_i2c_slv: assert property (p_en_i2c_slv)
        else $error("I2C1 slave enable not in bit 0");

    property p_unimpl;
        (interrupt_flag_status_4 & ~FLAG_IMPL) == 16'h0000 &&
        (interrupt_enable_control_1 & ~`IFB_EN_IMPL) == 16'h0000;
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("Unimplemented bit reads one");

    property p_rd_high;
        apb_rsp_out.pready |-> apb_rsp_out.prdata[31:16] == 16'h0000;
    endproperty
    a_rd_high: assert property (p_rd_high)
        else $error("Read data above bit 15 not zero");

    property p_reset;
        @(posedge mclk_in) disable iff (1'b0)
        reset_in |=> interrupt_flag_status_4 == `IFB_FLAG_RST &&
                     interrupt_enable_control_1 == `IFB_EN_RST &&
                     !irq_out && !apb_rsp_out.pready;
    endproperty
    a_reset: assert property (p_reset)
        else $error("Reset did not clear the bank");

    property p_sw_write;
        wr_flag && !(|(flag_req_in & FLAG_IMPL))
        |=> interrupt_flag_status_4 == ($past(wdata) & FLAG_IMPL);
    endproperty
    a_sw_write: assert property (p_sw_write)
        else $error("Software flag write not stored");

    property p_w1c;
        clr_flag && !(|flag_req_in)
        |=> interrupt_flag_status_4 ==
            ($past(interrupt_flag_status_4) & ~$past(wdata));
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("Write one to clear failed");

    property p_irq;
        clk_en_in && (interrupt_flag_status_4 & irq_mask_reg) != 16'h0000
        |=> irq_out;
    endproperty
    a_irq: assert property (p_irq)
        else $error("Unmasked flag gave no interrupt");

    property p_irq_quiet;
        clk_en_in && (interrupt_flag_status_4 & irq_mask_reg) == 16'h0000
        |=> !irq_out;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("Interrupt without an unmasked flag");

    property p_freeze;
        !clk_en_in |=> $stable(interrupt_flag_status_4) &&
                       $stable(interrupt_enable_control_1) &&
                       $stable(irq_out);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("State moved with clock enable low");

    property p_mask_unimpl;
        (irq_mask_reg & ~FLAG_IMPL) == 16'h0000;
    endproperty
    a_mask_unimpl: assert property (p_mask_unimpl)
        else $error("Unimplemented mask bit reads one");

    property p_en_write;
        wr_stb && addr == `IFB_OFS_ENABLE
        |=> interrupt_enable_control_1 == ($past(wdata) & `IFB_EN_IMPL);
    endproperty
    a_en_write: assert property (p_en_write)
        else $error("Enable write not stored");

    property p_flag_sticky;
        !wr_stb
        |=> (interrupt_flag_status_4 & $past(interrupt_flag_status_4)) ==
            $past(interrupt_flag_status_4);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("Flag dropped without a software write");

endmodule // ifb_bank

/* File: verification/ifb_source_model.sv */
`timescale 1ns/10ps

module ifb_source_model (
    input  wire logic        mclk_in,        // System clock
    output logic      [15:0] flag_req_out,   // Event request pulses
    output logic      [15:0] enable_req_out  // Gated source levels
);
    initial begin
        flag_req_out   = 16'h0000;
        enable_req_out = 16'h0000;
    end

    // Events are one-cycle pulses; the line falls back to idle after
    task automatic pulse(input logic [15:0] bits);
        @(posedge mclk_in);
        flag_req_out <= bits;
        @(posedge mclk_in);
        flag_req_out <= 16'h0000;
    endtask

    task automatic hold(input logic [15:0] bits);
        @(posedge mclk_in);
        enable_req_out <= bits;
    endtask
endmodule // ifb_source_model

/* File: verification/interrupt_flag_enable_bank_bench.sv */
`timescale 1ns/10ps
`include "ifb_regs.svh"

module interrupt_flag_enable_bank_bench
    import ifb_pkg::*;
;
    localparam logic [11:0] FLG = `IFB_OFS_FLAG;
    localparam logic [11:0] ENA = `IFB_OFS_ENABLE;
    localparam logic [11:0] MSK = `IFB_OFS_MASK;
    localparam logic [11:0] CLR = `IFB_OFS_FLAG_CLR;
    localparam logic [11:0] PND = `IFB_OFS_PENDING;

    logic         clk;
    logic         rst;
    logic         clk_en;
    ifb_apb_req_t req;
    ifb_apb_rsp_t rsp;
    ifb_apb_rsp_t rsp_nodac;
    logic [15:0]  flag_req;
    logic [15:0]  enable_req;
    logic [15:0]  gated;
    logic         irq;
    logic         irq_nodac;
    logic [15:0]  gated_nodac;
    logic [31:0]  rd;
    logic [31:0]  rd_nd;
    logic         err;
    int           miscompares;
    int           num_checks;
    int           flag_bit [6] = '{15, 14, 11, 10, 9, 3};
    int           en_bit   [5] = '{11, 7, 2, 1, 0};
    int           dead_bit [5] = '{13, 12, 8, 7, 0};

    ifb_bank #(.HAS_AUDIO_DAC(1)) dut (
        .mclk_in(clk), .reset_in(rst), .clk_en_in(clk_en),
        .apb_req_in(req), .apb_rsp_out(rsp), .flag_req_in(flag_req),
        .enable_req_in(enable_req), .gated_req_out(gated), .irq_out(irq));

    // Variant without the audio converter shares the bus and sources
    ifb_bank #(.HAS_AUDIO_DAC(0)) dut_nodac (
        .mclk_in(clk), .reset_in(rst), .clk_en_in(clk_en),
        .apb_req_in(req), .apb_rsp_out(rsp_nodac), .flag_req_in(flag_req),
        .enable_req_in(enable_req), .gated_req_out(gated_nodac),
        .irq_out(irq_nodac));

    ifb_source_model src (
        .mclk_in(clk), .flag_req_out(flag_req),
        .enable_req_out(enable_req));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic summarize;
        if (miscompares == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: bit %b want %b", $time, got, exp);
        end
    endtask

    // Request stands until pready is seen high at a rising edge
    task automatic apb_xfer(input logic is_wr, input logic [11:0] addr,
                            input logic [31:0] wdata,
                            output logic [31:0] rdata, output logic slverr);
        int n;
        n = 0;
        @(posedge clk);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= is_wr;
        req.paddr   <= addr;
        req.pwdata  <= wdata;
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) begin
            miscompares++;
            $display("unexpected at %0t: no ready", $time);
        end
        rdata  = rsp.prdata;
        slverr = rsp.pslverr;
        rd_nd  = rsp_nodac.prdata;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] addr, input logic [31:0] data);
        apb_xfer(1'b1, addr, data, rd, err);
    endtask

    task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
        apb_xfer(1'b0, addr, 32'h0000_0000, rd, err);
        chk_word(rd, exp);
        chk_bit(err, 1'b0);
    endtask

    task automatic settle;
        repeat (2) @(negedge clk);
    endtask

    initial begin
        #20000;
        miscompares++;
        summarize;
    end

    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        req = '0;
        miscompares = 0;
        num_checks = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        src.hold(16'hFFFF);
        for (int i = 0; i < 5; i++) rd_chk(12'(4 * i), 32'h0);
        apb_xfer(1'b0, 12'h014, 32'h0, rd, err);
        chk_bit(err, 1'b1);
        chk_word(rd, 32'h0);
        apb_xfer(1'b1, 12'h002, 32'h0000_FFFF, rd, err);
        chk_bit(err, 1'b1);
        rd_chk(FLG, 32'h0);
        wr(FLG, 32'hFFFF_FFFF);
        rd_chk(FLG, 32'h0000_CE7E);
        chk_word(rd_nd, 32'h0000_0E7E);
        wr(CLR, 32'h0000_FFFF);
        rd_chk(FLG, 32'h0);
        wr(ENA, 32'hFFFF_FFFF);
        rd_chk(ENA, 32'h0000_7FFF);
        settle;
        chk_word({16'h0, gated}, 32'h0000_7FFF);
        for (int i = 0; i < 5; i++) begin
            logic [31:0] one_hot;
            one_hot = 32'(1 << en_bit[i]);
            wr(ENA, one_hot);
            settle;
            chk_word({16'h0, gated}, one_hot);
            chk_word({16'h0, gated_nodac}, one_hot);
        end
        wr(ENA, 32'h0);
        settle;
        chk_word({16'h0, gated}, 32'h0);
        for (int i = 0; i < 6; i++) begin
            src.pulse(16'(1 << flag_bit[i]));
            settle;
            chk_bit(irq, 1'b0);
            rd_chk(FLG, 32'(1 << flag_bit[i]));
            wr(CLR, 32'(1 << flag_bit[i]));
            rd_chk(FLG, 32'h0);
        end
        for (int i = 0; i < 5; i++) begin
            src.pulse(16'(1 << dead_bit[i]));
            rd_chk(FLG, 32'h0);
        end
        wr(MSK, 32'h0000_FFFF);
        rd_chk(MSK, 32'h0000_CE7E);
        chk_word(rd_nd, 32'h0000_0E7E);
        src.pulse(16'hC000);
        settle;
        chk_bit(irq, 1'b1);
        chk_bit(irq_nodac, 1'b0);
        rd_chk(PND, 32'h0000_C000);
        chk_word(rd_nd, 32'h0);
        wr(CLR, 32'h0000_FFFF);
        settle;
        chk_bit(irq, 1'b0);
        src.pulse(16'h0800);
        settle;
        chk_bit(irq, 1'b1);
        chk_bit(irq_nodac, 1'b1);
        wr(MSK, 32'h0);
        settle;
        chk_bit(irq, 1'b0);
        rd_chk(PND, 32'h0);
        rd_chk(FLG, 32'h0000_0800);
        wr(FLG, 32'h0);
        rd_chk(FLG, 32'h0);
        // Error flag lands, then the bank freezes and ignores a request
        src.pulse(16'h0200);
        clk_en <= 1'b0;
        src.pulse(16'h0008);
        @(posedge clk);
        clk_en <= 1'b1;
        rd_chk(FLG, 32'h0000_0200);
        wr(FLG, 32'hFFFF_FFFF);
        wr(ENA, 32'hFFFF_FFFF);
        wr(MSK, 32'hFFFF_FFFF);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) rd_chk(12'(4 * i), 32'h0);
        chk_word({16'h0, gated}, 32'h0);
        chk_bit(irq, 1'b0);
        summarize;
    end
endmodule // interrupt_flag_enable_bank_bench
